// File: common/sipr_defines.vh
`ifndef SIPR_DEFINES_VH
`define SIPR_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define SIPR_ADDR_CTRL      12'h000
`define SIPR_ADDR_ROUTE     12'h004
`define SIPR_ADDR_SRC       12'h008
`define SIPR_ADDR_STATUS    12'h00c
`define SIPR_ADDR_IRQ_REQ   12'h010
`define SIPR_ADDR_W         12

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define SIPR_CTRL_MODE_LO   0
`define SIPR_CTRL_MODE_HI   1
`define SIPR_CTRL_INTA_EN   2
`define SIPR_CTRL_MUX_EN    3
`define SIPR_CTRL_PME_SEL   4
`define SIPR_CTRL_SER_PCI   5
`define SIPR_CTRL_W         6
`define SIPR_CTRL_RESET     6'h00

// interrupt modes
`define SIPR_MODE_PAR_PCI   2'h0
`define SIPR_MODE_PAR_ISA   2'h1
`define SIPR_MODE_SER_ISA   2'h2
`define SIPR_MODE_SER_ALL   2'h3

// ----------------------------------------------------------------------------
// routing register: four bits per output, code 0 = no source
// ----------------------------------------------------------------------------
`define SIPR_ROUTE_RESET    32'h0000_0000
`define SIPR_IRQ_CODE_W     4
`define SIPR_IRQ_NONE       4'h0
`define SIPR_NUM_MUX        8
`define SIPR_NUM_IRQ        16

// secondary function select register: two bits per output
`define SIPR_SRC_RESET      16'h0000
`define SIPR_SEC_IRQ        2'h0
`define SIPR_SEC_INTB       2'h1
`define SIPR_SEC_DMA        2'h2
`define SIPR_SEC_RING       2'h3

`endif

// File: hdl/sipr_apb_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "sipr_defines.vh"

// apb slave holding the control and routing registers
module sipr_apb_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [31:0] status_in,     // live pin state for readback
  output reg  [5:0]  ctrl_q,
  output reg  [31:0] route_q,
  output reg  [15:0] src_q,
  output reg  [15:0] irq_req_q
);

  wire access;
  wire mapped;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // zero wait states; unmapped addresses answer with pslverr
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign mapped  = (paddr == `SIPR_ADDR_CTRL) || (paddr == `SIPR_ADDR_ROUTE) ||
                   (paddr == `SIPR_ADDR_SRC) || (paddr == `SIPR_ADDR_STATUS) ||
                   (paddr == `SIPR_ADDR_IRQ_REQ);
  assign pslverr = access & ~mapped;

  // write side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= `SIPR_CTRL_RESET;
      route_q   <= `SIPR_ROUTE_RESET;
      src_q     <= `SIPR_SRC_RESET;
      irq_req_q <= 16'h0000;
    end else if (access && pwrite) begin
      case (paddr)
        `SIPR_ADDR_CTRL:    ctrl_q    <= pwdata[5:0];
        `SIPR_ADDR_ROUTE:   route_q   <= pwdata;
        `SIPR_ADDR_SRC:     src_q     <= pwdata[15:0];
        `SIPR_ADDR_IRQ_REQ: irq_req_q <= pwdata[15:0];
        default: ;                     // status is read only
      endcase
    end
  end

  // read data registered during setup so it is valid in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SIPR_ADDR_CTRL:    prdata <= {26'h0000000, ctrl_q};
        `SIPR_ADDR_ROUTE:   prdata <= route_q;
        `SIPR_ADDR_SRC:     prdata <= {16'h0000, src_q};
        `SIPR_ADDR_STATUS:  prdata <= status_in;
        `SIPR_ADDR_IRQ_REQ: prdata <= {16'h0000, irq_req_q};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: hdl/sipr_mux_lane.v
`timescale 1ns/100ps
`default_nettype none
`include "sipr_defines.vh"

// one interrupt multiplexer output with registered level
module sipr_mux_lane (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        enable,        // multiplexer outputs enabled
  input  wire [3:0]  irq_code,      // routed irq number, 0 = none
  input  wire [1:0]  sec_sel,       // secondary function select
  input  wire [15:0] irq_req,       // isa-style request levels
  input  wire        intb_lvl,      // pci intb level, active high
  input  wire        dma_lvl,       // dma request or grant level
  input  wire        ring_lvl,      // ring indicate level
  output reg         mux_out_q      // registered output level
);

  reg mux_out_d;

  // --------------------------------------------------------------------------
  // selection
  // --------------------------------------------------------------------------
  // secondary function overrides routed irq entirely
  always @* begin
    mux_out_d = 1'b0;
    case (sec_sel)
      `SIPR_SEC_INTB: mux_out_d = intb_lvl;
      `SIPR_SEC_DMA:  mux_out_d = dma_lvl;
      `SIPR_SEC_RING: mux_out_d = ring_lvl;
      default: begin
        // unrouted or disabled outputs stay low
        if (enable && irq_code != `SIPR_IRQ_NONE) begin
          mux_out_d = irq_req[irq_code];
        end
      end
    endcase
  end

  // output register keeps pin free of glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_out_q <= 1'b0;
    end else begin
      mux_out_q <= mux_out_d;
    end
  end

endmodule

`default_nettype wire

// File: hdl/sipr_top.v
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sipr_defines.vh"

module sipr_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        inta_req,              // internal pci inta level, high = asserted
  input  wire        intb_req,              // internal pci intb level
  input  wire        dma_channel_request,   // dma request from internal dma logic
  input  wire        dma_channel_grant,     // dma grant level
  input  wire        ring_event,            // ring indicate level
  input  wire        pme_event,             // power management event level
  input  wire        general_io_pin_three_i,
  output reg         general_io_pin_three_o,
  output reg         general_io_pin_three_oe,
  input  wire        serial_irq_line_i,
  output reg         serial_irq_line_o,
  output reg         serial_irq_line_oe,
  output wire [7:0]  interrupt_mux_output,
  output reg         ring_indicate_output,
  output reg         serial_pci_inta,       // request to serial frame logic
  output reg         serial_pci_intb,
  output reg  [15:0] serial_irq_levels,     // isa levels to serial frame logic
  output wire        serial_mode
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  wire [5:0]  ctrl_q;
  wire [31:0] route_q;
  wire [15:0] src_q;
  wire [15:0] irq_req_q;
  wire [31:0] status;
  wire [1:0]  mode;
  wire        parallel;
  reg         pin3_in_q;                     // sampled pin three level

  assign mode     = ctrl_q[`SIPR_CTRL_MODE_HI:`SIPR_CTRL_MODE_LO];
  assign parallel = (mode == `SIPR_MODE_PAR_PCI) || (mode == `SIPR_MODE_PAR_ISA);
  assign serial_mode = ~parallel;

  // live state for software in bits 18:6: pin three input, serial line, ring out,
  // pin three enable, serial drive and the eight mux outputs
  assign status = {13'h0000, pin3_in_q, serial_irq_line_i, ring_indicate_output,
                   general_io_pin_three_oe, serial_irq_line_o, interrupt_mux_output, 6'h00};

  sipr_apb_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .status_in (status),
    .ctrl_q    (ctrl_q),
    .route_q   (route_q),
    .src_q     (src_q),
    .irq_req_q (irq_req_q)
  );

  // --------------------------------------------------------------------------
  // interrupt multiplexer outputs
  // --------------------------------------------------------------------------
  // parallel isa mode required for routed irqs; routing may be written before or after the mode
  wire mux_enable;
  wire dma_lvl;
  assign mux_enable = ctrl_q[`SIPR_CTRL_MUX_EN] && (mode == `SIPR_MODE_PAR_ISA);
  assign dma_lvl    = dma_channel_request | dma_channel_grant;

  genvar gi;
  generate
    for (gi = 0; gi < `SIPR_NUM_MUX; gi = gi + 1) begin : g_lane
      sipr_mux_lane u_lane (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (mux_enable),
        .irq_code  (route_q[gi*4 +: 4]),
        .sec_sel   (src_q[gi*2 +: 2]),
        .irq_req   (irq_req_q),
        .intb_lvl  (intb_req),
        .dma_lvl   (dma_lvl),
        .ring_lvl  (ring_event),
        .mux_out_q (interrupt_mux_output[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // pin three, serial line, ring output
  // --------------------------------------------------------------------------
  // pin three and serial line are open-drain style: drive low when active
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin3_in_q               <= 1'b0;
      general_io_pin_three_o  <= 1'b0;
      general_io_pin_three_oe <= 1'b0;       // input after reset
      serial_irq_line_o       <= 1'b0;
      serial_irq_line_oe      <= 1'b0;
      ring_indicate_output    <= 1'b0;
      serial_pci_inta         <= 1'b0;
      serial_pci_intb         <= 1'b0;
      serial_irq_levels       <= 16'h0000;
    end else begin
      pin3_in_q <= general_io_pin_three_i;
      // inta only when enabled and parallel, else stays an input
      general_io_pin_three_o  <= 1'b0;
      general_io_pin_three_oe <= ctrl_q[`SIPR_CTRL_INTA_EN] & parallel & inta_req;
      // parallel mode turns serial line into intb
      serial_irq_line_o  <= 1'b0;
      serial_irq_line_oe <= parallel & intb_req;
      // levels handed to serial frame logic only in serial modes
      serial_irq_levels <= parallel ? 16'h0000 : irq_req_q;
      serial_pci_inta   <= ~parallel & ctrl_q[`SIPR_CTRL_SER_PCI] & inta_req;
      serial_pci_intb   <= ~parallel & ctrl_q[`SIPR_CTRL_SER_PCI] & intb_req;
      // ring or pme by configuration
      ring_indicate_output <= ctrl_q[`SIPR_CTRL_PME_SEL] ? pme_event : ring_event;
    end
  end

endmodule

`default_nettype wire

// File: verification/sipr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the shared interrupt lines
module sipr_host_model (
  input  wire logic pin3_oe,
  input  wire logic pin3_o,
  input  wire logic ser_oe,
  input  wire logic ser_o,
  output logic      pin3_wire,
  output logic      ser_wire,
  output logic      inta_seen,
  output logic      intb_seen
);
  // pulled-up lines: a released line reads high, never its last value
  assign pin3_wire = pin3_oe ? pin3_o : 1'b1;
  assign ser_wire  = ser_oe ? ser_o : 1'b1;
  // requests are active low on the wire
  assign inta_seen = ~pin3_wire;
  assign intb_seen = ~ser_wire;
endmodule
`default_nettype wire

// File: verification/sipr_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sipr_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        inta_req,
  input wire logic        intb_req,
  input wire logic        dma_channel_request,
  input wire logic        dma_channel_grant,
  input wire logic        ring_event,
  input wire logic        pme_event,
  input wire logic        general_io_pin_three_o,
  input wire logic        general_io_pin_three_oe,
  input wire logic        serial_irq_line_oe,
  input wire logic [7:0]  interrupt_mux_output,
  input wire logic        ring_indicate_output,
  input wire logic        serial_mode
);
  // ------------------------------------------------------------
  // shadow copies of the registers, updated at the access edge
  // ------------------------------------------------------------
  logic [5:0]  ctrl_q;
  logic [31:0] route_q;
  logic [15:0] src_q;
  logic [15:0] req_q;
  logic [7:0]  mux_d;   // expected lane levels
  wire         wr = psel & penable & pwrite & pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 6'h00;
      route_q <= 32'h0;
      src_q   <= 16'h0;
      req_q   <= 16'h0;
    end else if (wr) begin
      if (paddr == 12'h000) ctrl_q <= pwdata[5:0];
      if (paddr == 12'h004) route_q <= pwdata;
      if (paddr == 12'h008) src_q <= pwdata[15:0];
      if (paddr == 12'h010) req_q <= pwdata[15:0];
    end
  end
  // secondary function wins over the routed irq on its lane
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      case (src_q[2*n+:2])
        2'h1: mux_d[n] = intb_req;
        2'h2: mux_d[n] = dma_channel_request | dma_channel_grant;
        2'h3: mux_d[n] = ring_event;
        default: mux_d[n] = (ctrl_q[1:0] == 2'h1) & ctrl_q[3] & (route_q[4*n+:4] != 4'h0)
                            & req_q[route_q[4*n+:4]];
      endcase
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pin_low_a: assert property (general_io_pin_three_o == 1'b0)
    else $error("pin three driven high");
  // the edge just after a reset release still shows the reset levels
  inta_pin_a: assert property (general_io_pin_three_oe ==
    ($past(presetn) ? $past(ctrl_q[2] & ~ctrl_q[1] & inta_req) : 1'b0))
    else $error("pin three level wrong");
  intb_ser_a: assert property (serial_irq_line_oe ==
    ($past(presetn) ? $past(~ctrl_q[1] & intb_req) : 1'b0))
    else $error("serial line level wrong");
  ring_out_a: assert property (ring_indicate_output ==
    ($past(presetn) ? $past(ctrl_q[4] ? pme_event : ring_event) : 1'b0))
    else $error("ring output wrong");
  mux_lane_a: assert property (interrupt_mux_output ==
    ($past(presetn) ? $past(mux_d) : 8'h00))
    else $error("mux outputs wrong");
  ser_mode_a: assert property (serial_mode == ctrl_q[1])
    else $error("serial mode flag wrong");
  apb_ready_a: assert property (psel & penable |-> pready)
    else $error("no ready in access");
  bad_addr_a: assert property (psel & penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}))
    else $error("error response wrong");
  rd_ctrl_a: assert property (psel & penable & !pwrite & paddr == 12'h000 |-> prdata == {26'h0, ctrl_q})
    else $error("control readback wrong");
  cover property (serial_irq_line_oe);
  cover property (interrupt_mux_output == 8'hff);
  cover property (psel & penable & pslverr);
endmodule
bind sipr_top sipr_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .inta_req, .intb_req, .dma_channel_request, .dma_channel_grant,
  .ring_event, .pme_event, .general_io_pin_three_o, .general_io_pin_three_oe,
  .serial_irq_line_oe, .interrupt_mux_output, .ring_indicate_output, .serial_mode);
`default_nettype wire

// File: verification/sipr_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module sipr_top_tb_top;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        inta_req = 1'b0, intb_req = 1'b0, dma_channel_request = 1'b0;
  logic        dma_channel_grant = 1'b0, ring_event = 1'b0, pme_event = 1'b0;
  logic        pready, pslverr, err, serial_pci_inta, serial_pci_intb, serial_mode;
  logic        general_io_pin_three_i, general_io_pin_three_o, general_io_pin_three_oe;
  logic        serial_irq_line_i, serial_irq_line_o, serial_irq_line_oe;
  logic        ring_indicate_output, inta_seen, intb_seen;
  logic [7:0]  interrupt_mux_output;
  logic [15:0] serial_irq_levels;
  int          fail_count = 0, tests_run = 0;
  logic [7:0]  sec_codes = 8'he9;   // lane codes in turn: intb, dma, dma, ring

  always #10 pclk = ~pclk;

  sipr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .inta_req, .intb_req, .dma_channel_request, .dma_channel_grant, .ring_event,
    .pme_event, .general_io_pin_three_i, .general_io_pin_three_o, .general_io_pin_three_oe,
    .serial_irq_line_i, .serial_irq_line_o, .serial_irq_line_oe, .interrupt_mux_output,
    .ring_indicate_output, .serial_pci_inta, .serial_pci_intb, .serial_irq_levels, .serial_mode);
  sipr_host_model host (.pin3_oe(general_io_pin_three_oe), .pin3_o(general_io_pin_three_o),
    .ser_oe(serial_irq_line_oe), .ser_o(serial_irq_line_o), .pin3_wire(general_io_pin_three_i),
    .ser_wire(serial_irq_line_i), .inta_seen, .intb_seen);

  task test_done;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // outputs follow one edge after the cause
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    inta_req <= 1'b1;
    intb_req <= 1'b1;
    settle;
    chk(general_io_pin_three_i, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // every mode, inta on pin three and pci in stream requested
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h000, 32'h24 | m);
      settle;
      chk(inta_seen, m < 2);
      chk(intb_seen, m < 2);
      chk(serial_mode, m > 1);
      chk({serial_pci_inta, serial_pci_intb}, (m > 1) ? 2'h3 : 2'h0);
    end
    // serial mode without the pci bit keeps pci requests out of the stream
    apb(1'b1, 12'h000, 32'h03);
    settle;
    chk({serial_pci_inta, serial_pci_intb}, 2'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h03);
    apb(1'b1, 12'h010, 32'h8002);
    settle;
    chk(serial_irq_levels, 16'h8002);
    @(posedge pclk) {inta_req, intb_req} <= 2'h0;
    // routing before enable, then all fifteen codes
    apb(1'b1, 12'h004, 32'h11111111);
    apb(1'b1, 12'h000, 32'h09);
    for (int k = 1; k < 16; k++) begin
      apb(1'b1, 12'h004, {8{k[3:0]}});
      apb(1'b1, 12'h010, 32'h1 << k);
      settle;
      chk(interrupt_mux_output, 8'hff);
      apb(1'b1, 12'h010, ~(32'h1 << k));
      settle;
      chk(interrupt_mux_output, 8'h00);
    end
    apb(1'b1, 12'h004, 32'h0);
    settle;
    chk(interrupt_mux_output, 8'h00);
    apb(1'b1, 12'h004, 32'h11111111);
    apb(1'b1, 12'h000, 32'h01);
    settle;
    chk(interrupt_mux_output, 8'h00);
    apb(1'b1, 12'h000, 32'h09);
    // secondary sources: intb, dma request, dma grant, ring
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h008, {16'h0000, {8{sec_codes[2*i +: 2]}}});
      settle;
      chk(interrupt_mux_output, 8'h00);
      @(posedge pclk) {ring_event, dma_channel_grant, dma_channel_request, intb_req} <= 4'h1 << i;
      settle;
      chk(interrupt_mux_output, 8'hff);
      @(posedge pclk) {ring_event, dma_channel_grant, dma_channel_request, intb_req} <= 4'h0;
    end
    apb(1'b1, 12'h000, 32'h00);
    @(posedge pclk) ring_event <= 1'b1;
    settle;
    chk(ring_indicate_output, 1'b1);
    apb(1'b1, 12'h000, 32'h10);
    settle;
    chk(ring_indicate_output, 1'b0);
    @(posedge pclk) pme_event <= 1'b1;
    settle;
    chk(ring_indicate_output, 1'b1);
    // live pin state and routing readback
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0007_3fc0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1111_1111);
    // pin three carries inta, then a second reset returns it to an input
    apb(1'b1, 12'h000, 32'h04);
    @(posedge pclk) {inta_req, ring_event, pme_event} <= 3'h4;
    settle;
    chk(inta_seen, 1'b1);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk(general_io_pin_three_i, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
